//--- logic/dmsau_pkg.sv
package dmsau_pkg;
  localparam int unsigned WORD_W       = 16;
  localparam int unsigned WIDE_W       = 32;
  localparam int unsigned PTR_W        = 3;
  localparam int unsigned NUM_PTRS     = 8;
  localparam int unsigned SHIFT_W      = 5;
  localparam int unsigned SHIFT_MAX    = 16;
  localparam int unsigned PS_LEFT4_AMT = 4;
  localparam int unsigned PS_RIGHT_AMT = 6;
  localparam int unsigned CLK_PERIOD_NS = 100;
  // Data-space addresses of the pointer registers
  localparam logic [15:0] PTR_MMR_BASE = 16'h0010;
  localparam logic [31:0] PROD_RESET   = 32'h0000_0000;
  localparam logic [15:0] WORD_RESET   = 16'h0000;

  typedef enum logic [1:0] {
    DMSAU_PS_NONE, DMSAU_PS_LEFT1, DMSAU_PS_LEFT4, DMSAU_PS_RIGHT6
  } dmsau_ps_e;

  typedef enum logic [1:0] {
    DMSAU_BIT_SET, DMSAU_BIT_CLEAR, DMSAU_BIT_TEST, DMSAU_BIT_TOGGLE
  } dmsau_bitop_e;

  typedef enum logic [1:0] {
    DMSAU_STEP_NONE, DMSAU_STEP_INC, DMSAU_STEP_DEC, DMSAU_STEP_INDEX
  } dmsau_step_e;

  typedef enum logic [1:0] {
    DMSAU_LSRC_MEM, DMSAU_LSRC_SUM, DMSAU_LSRC_PROD, DMSAU_LSRC_IMM
  } dmsau_lsrc_e;
endpackage

//--- logic/dmsau_ptr_file.sv
`timescale 1ns/10ps
`default_nettype none
module dmsau_ptr_file
  import dmsau_pkg::*;
(
  input  wire logic                clk_sys_in,
  input  wire logic                reset_n_in,
  input  wire logic                wr_en_in,
  input  wire logic [PTR_W-1:0]    wr_idx_in,
  input  wire logic [WORD_W-1:0]   wr_data_in,
  input  wire logic [PTR_W-1:0]    rd_idx_in,
  output logic      [WORD_W-1:0]   rd_data_out,
  output logic      [WORD_W-1:0]   cur_now_out,
  input  wire logic [PTR_W-1:0]    cur_idx_in
);
  logic [WORD_W-1:0] regs_reg [NUM_PTRS];
  logic [WORD_W-1:0] regs_next [NUM_PTRS];
  logic [WORD_W-1:0] rd_data_reg;
  logic [WORD_W-1:0] rd_data_next;

  always_comb begin
    for (int i = 0; i < NUM_PTRS; i++) begin
      regs_next[i] = regs_reg[i];
    end
    if (wr_en_in) begin
      regs_next[wr_idx_in] = wr_data_in;
    end
    rd_data_next = regs_reg[rd_idx_in];
  end

  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      for (int i = 0; i < NUM_PTRS; i++) begin
        regs_reg[i] <= WORD_RESET;
      end
      rd_data_reg <= WORD_RESET;
    end else begin
      for (int i = 0; i < NUM_PTRS; i++) begin
        regs_reg[i] <= regs_next[i];
      end
      rd_data_reg <= rd_data_next;
    end
  end

  assign rd_data_out = rd_data_reg;
  // Combinational view of current pointer for same-cycle addressing
  assign cur_now_out = regs_reg[cur_idx_in];
endmodule
`default_nettype wire

//--- logic/dmsau_core.sv
`timescale 1ns/10ps
`default_nettype none
module dmsau_core
  import dmsau_pkg::*;
(
  input  wire logic                    clk_sys_in,
  input  wire logic                    reset_n_in,
  // Scaling shifter
  input  wire logic [WORD_W-1:0]       scale_data_in,
  input  wire logic [SHIFT_W-1:0]      scale_imm_in,
  input  wire logic                    scale_use_count_in,
  input  wire logic [3:0]              shift_count_register_in,
  input  wire logic                    sign_extend_mode_in,
  output logic      [WIDE_W-1:0]       scale_result_out,
  // Bit logic unit
  input  wire logic                    bit_logic_unit_en_in,
  input  wire dmsau_pkg::dmsau_bitop_e bit_op_in,
  input  wire logic [WORD_W-1:0]       bit_mem_in,
  input  wire logic [WORD_W-1:0]       bit_mask_in,
  output logic      [WORD_W-1:0]       bit_result_out,
  output logic                         bit_write_out,
  output logic                         bit_test_out,
  // Multiplier
  input  wire logic                    operand_load_op_in,
  input  wire logic [WORD_W-1:0]       operand_data_in,
  input  wire logic                    signed_multiply_op_in,
  input  wire logic                    unsigned_multiply_op_in,
  input  wire logic [WORD_W-1:0]       mult_data_in,
  input  wire logic [1:0]              product_shift_field_in,
  output logic      [WORD_W-1:0]       multiplier_operand_register_out,
  output logic      [WIDE_W-1:0]       product_register_out,
  output logic      [WIDE_W-1:0]       product_shifted_out,
  // Multiply-accumulate under repeat
  input  wire logic                    mac_start_in,
  input  wire logic                    repeat_clear_op_in,
  input  wire logic                    mac_move_in,
  input  wire logic [7:0]              repeat_count_in,
  input  wire logic [WORD_W-1:0]       coef_start_in,
  input  wire logic [WORD_W-1:0]       prog_data_in,
  input  wire logic [WORD_W-1:0]       data_bus_in,
  input  wire dmsau_pkg::dmsau_step_e  mac_step_in,
  output logic      [WORD_W-1:0]       coef_addr_out,
  output logic      [WORD_W-1:0]       data_addr_out,
  output logic      [WORD_W-1:0]       move_addr_out,
  output logic      [WORD_W-1:0]       move_data_out,
  output logic                         move_write_out,
  output logic                         mac_busy_out,
  output logic      [WIDE_W-1:0]       main_sum_register_out,
  // Pointer file and address unit
  input  wire logic                    ptr_load_in,
  input  wire dmsau_pkg::dmsau_lsrc_e  ptr_src_in,
  input  wire logic [PTR_W-1:0]        ptr_load_idx_in,
  input  wire logic [WORD_W-1:0]       ptr_mem_in,
  input  wire logic [WORD_W-1:0]       ptr_imm_in,
  input  wire logic                    pointer_select_load_in,
  input  wire logic [PTR_W-1:0]        pointer_select_in,
  input  wire logic                    ptr_access_in,
  input  wire dmsau_pkg::dmsau_step_e  ptr_step_in,
  input  wire logic [WORD_W-1:0]       index_step_register_in,
  output logic      [WORD_W-1:0]       ptr_access_addr_out,
  output logic      [PTR_W-1:0]        pointer_select_out,
  input  wire logic                    mmr_rd_in,
  input  wire logic                    mmr_wr_in,
  input  wire logic [WORD_W-1:0]       mmr_addr_in,
  input  wire logic [WORD_W-1:0]       mmr_wdata_in,
  output logic      [WORD_W-1:0]       mmr_rdata_out
);
  import dmsau_pkg::*;

  typedef enum logic [1:0] {DMSAU_IDLE, DMSAU_RUN} dmsau_mac_e;

  logic [WIDE_W-1:0] scale_reg, scale_next;
  logic [WORD_W-1:0] bit_res_reg, bit_res_next;
  logic              bit_wr_reg, bit_wr_next, bit_test_reg, bit_test_next;
  logic [WORD_W-1:0] treg_reg, treg_next;
  logic [WIDE_W-1:0] prod_reg, prod_next;
  logic [WIDE_W-1:0] psh_reg, psh_next;
  logic [WIDE_W-1:0] sum_reg, sum_next;
  dmsau_mac_e        mac_st_reg, mac_st_next;
  logic [7:0]        cnt_reg, cnt_next;
  logic              move_reg, move_next;
  logic [WORD_W-1:0] coef_reg, coef_next;
  logic [WORD_W-1:0] daddr_reg, daddr_next;
  logic [WORD_W-1:0] maddr_reg, maddr_next;
  logic [WORD_W-1:0] mdata_reg, mdata_next;
  logic              mwr_reg, mwr_next;
  logic [WORD_W-1:0] paddr_reg, paddr_next;
  logic [PTR_W-1:0]  sel_reg, sel_next;
  logic              mmr_rd_reg;
  logic              mmr_rd_next;

  logic [WORD_W-1:0] cur_ptr;
  logic [WORD_W-1:0] ptr_rd;
  logic              pf_wr;
  logic [PTR_W-1:0]  pf_idx;
  logic [WORD_W-1:0] pf_data;
  logic              mmr_hit;
  logic [PTR_W-1:0]  mmr_idx;

  function automatic logic [WORD_W-1:0] step_ptr(input logic [WORD_W-1:0] p,
                                                 input dmsau_step_e s,
                                                 input logic [WORD_W-1:0] ix);
    case (s)
      DMSAU_STEP_INC:   step_ptr = p + 16'h0001;
      DMSAU_STEP_DEC:   step_ptr = p - 16'h0001;
      DMSAU_STEP_INDEX: step_ptr = p + ix;
      default:          step_ptr = p;
    endcase
  endfunction

  function automatic logic [WIDE_W-1:0] mul(input logic [WORD_W-1:0] a,
                                            input logic [WORD_W-1:0] b,
                                            input logic              uns);
    if (uns) begin
      mul = WIDE_W'(a) * WIDE_W'(b);
    end else begin
      mul = WIDE_W'($signed(a)) * WIDE_W'($signed(b));
    end
  endfunction

  // Scaling shifter
  logic [SHIFT_W-1:0] sh_amt;
  logic [WIDE_W-1:0]  sh_ext;
  always_comb begin
    sh_amt = scale_use_count_in ? {1'b0, shift_count_register_in} : scale_imm_in;
    if (sh_amt > SHIFT_W'(SHIFT_MAX)) begin
      sh_amt = SHIFT_W'(SHIFT_MAX);
    end
    sh_ext = sign_extend_mode_in ? {{WORD_W{scale_data_in[WORD_W-1]}}, scale_data_in}
                                 : {{WORD_W{1'b0}}, scale_data_in};
    scale_next = sh_ext << sh_amt;
  end

  // Bit logic unit, never touches the sum
  always_comb begin
    bit_res_next  = bit_mem_in;
    bit_wr_next   = 1'b0;
    bit_test_next = bit_test_reg;
    if (bit_logic_unit_en_in) begin
      case (bit_op_in)
        DMSAU_BIT_SET:    bit_res_next = bit_mem_in | bit_mask_in;
        DMSAU_BIT_CLEAR:  bit_res_next = bit_mem_in & ~bit_mask_in;
        DMSAU_BIT_TOGGLE: bit_res_next = bit_mem_in ^ bit_mask_in;
        default:          bit_test_next = |(bit_mem_in & bit_mask_in);
      endcase
      bit_wr_next = (bit_op_in != DMSAU_BIT_TEST);
    end
  end

  // Product shifter on the product register input (prod_next), registered into psh_reg
  always_comb begin
    case (dmsau_ps_e'(product_shift_field_in))
      DMSAU_PS_LEFT1:  psh_next = prod_next << 1;
      DMSAU_PS_LEFT4:  psh_next = prod_next << PS_LEFT4_AMT;
      DMSAU_PS_RIGHT6: psh_next = WIDE_W'($signed(prod_next) >>> PS_RIGHT_AMT);
      default:         psh_next = prod_next;
    endcase
  end

  // Multiplier, accumulate sequencer and address unit
  always_comb begin
    treg_next   = treg_reg;
    prod_next   = prod_reg;
    sum_next    = sum_reg;
    mac_st_next = mac_st_reg;
    cnt_next    = cnt_reg;
    move_next   = move_reg;
    coef_next   = coef_reg;
    daddr_next  = daddr_reg;
    maddr_next  = maddr_reg;
    mdata_next  = mdata_reg;
    mwr_next    = 1'b0;
    paddr_next  = paddr_reg;
    sel_next    = sel_reg;
    pf_wr       = 1'b0;
    pf_idx      = sel_reg;
    pf_data     = cur_ptr;
    mmr_hit     = (mmr_addr_in[15:PTR_W] == PTR_MMR_BASE[15:PTR_W]);
    mmr_idx     = mmr_addr_in[PTR_W-1:0];
    mmr_rd_next = mmr_rd_in && mmr_hit;

    if (operand_load_op_in) begin
      treg_next = operand_data_in;
    end
    if (signed_multiply_op_in || unsigned_multiply_op_in) begin
      prod_next = mul(treg_reg, mult_data_in, unsigned_multiply_op_in);
    end

    case (mac_st_reg)
      DMSAU_IDLE: begin
        if (mac_start_in) begin
          mac_st_next = DMSAU_RUN;
          cnt_next    = repeat_count_in;
          move_next   = mac_move_in;
          coef_next   = coef_start_in;
          daddr_next  = cur_ptr;
          if (repeat_clear_op_in) begin
            sum_next  = PROD_RESET;
            prod_next = PROD_RESET;
          end
        end
      end
      DMSAU_RUN: begin
        sum_next  = sum_reg + psh_reg;
        prod_next = mul(prog_data_in, data_bus_in, 1'b0);
        coef_next = coef_reg + 16'h0001;
        daddr_next = step_ptr(cur_ptr, mac_step_in, index_step_register_in);
        pf_wr     = 1'b1;
        pf_data   = daddr_next;
        if (move_reg) begin
          maddr_next = cur_ptr + 16'h0001;
          mdata_next = data_bus_in;
          mwr_next   = 1'b1;
        end
        if (cnt_reg == 8'h00) begin
          mac_st_next = DMSAU_IDLE;
        end else begin
          cnt_next = cnt_reg - 8'h01;
        end
      end
      default: mac_st_next = DMSAU_IDLE;
    endcase

    if (mac_st_reg == DMSAU_IDLE) begin
      if (ptr_access_in) begin
        paddr_next = cur_ptr;
        pf_wr      = 1'b1;
        pf_data    = step_ptr(cur_ptr, ptr_step_in, index_step_register_in);
      end
      if (ptr_load_in) begin
        pf_wr  = 1'b1;
        pf_idx = ptr_load_idx_in;
        case (ptr_src_in)
          DMSAU_LSRC_SUM:  pf_data = sum_reg[WORD_W-1:0];
          DMSAU_LSRC_PROD: pf_data = prod_reg[WORD_W-1:0];
          DMSAU_LSRC_IMM:  pf_data = ptr_imm_in;
          default:         pf_data = ptr_mem_in;
        endcase
      end else if (mmr_wr_in && mmr_hit) begin
        pf_wr   = 1'b1;
        pf_idx  = mmr_idx;
        pf_data = mmr_wdata_in;
      end
    end
    if (pointer_select_load_in) begin
      sel_next = pointer_select_in;
    end
  end

  dmsau_ptr_file u_ptr_file (
    .clk_sys_in  (clk_sys_in),
    .reset_n_in  (reset_n_in),
    .wr_en_in    (pf_wr),
    .wr_idx_in   (pf_idx),
    .wr_data_in  (pf_data),
    .rd_idx_in   (mmr_idx),
    .rd_data_out (ptr_rd),
    .cur_now_out (cur_ptr),
    .cur_idx_in  (sel_reg)
  );

  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      scale_reg    <= PROD_RESET;
      bit_res_reg  <= WORD_RESET;
      bit_wr_reg   <= 1'b0;
      bit_test_reg <= 1'b0;
      treg_reg     <= WORD_RESET;
      prod_reg     <= PROD_RESET;
      psh_reg      <= PROD_RESET;
      sum_reg      <= PROD_RESET;
      mac_st_reg   <= DMSAU_IDLE;
      cnt_reg      <= 8'h00;
      move_reg     <= 1'b0;
      coef_reg     <= WORD_RESET;
      daddr_reg    <= WORD_RESET;
      maddr_reg    <= WORD_RESET;
      mdata_reg    <= WORD_RESET;
      mwr_reg      <= 1'b0;
      paddr_reg    <= WORD_RESET;
      sel_reg      <= '0;
      mmr_rd_reg   <= 1'b0;
    end else begin
      scale_reg    <= scale_next;
      bit_res_reg  <= bit_res_next;
      bit_wr_reg   <= bit_wr_next;
      bit_test_reg <= bit_test_next;
      treg_reg     <= treg_next;
      prod_reg     <= prod_next;
      psh_reg      <= psh_next;
      sum_reg      <= sum_next;
      mac_st_reg   <= mac_st_next;
      cnt_reg      <= cnt_next;
      move_reg     <= move_next;
      coef_reg     <= coef_next;
      daddr_reg    <= daddr_next;
      maddr_reg    <= maddr_next;
      mdata_reg    <= mdata_next;
      mwr_reg      <= mwr_next;
      paddr_reg    <= paddr_next;
      sel_reg      <= sel_next;
      mmr_rd_reg   <= mmr_rd_next;
    end
  end

  assign scale_result_out                = scale_reg;
  assign bit_result_out                  = bit_res_reg;
  assign bit_write_out                   = bit_wr_reg;
  assign bit_test_out                    = bit_test_reg;
  assign multiplier_operand_register_out = treg_reg;
  assign product_register_out            = prod_reg;
  assign product_shifted_out             = psh_reg;
  assign main_sum_register_out           = sum_reg;
  assign coef_addr_out                   = coef_reg;
  assign data_addr_out                   = daddr_reg;
  assign move_addr_out                   = maddr_reg;
  assign move_data_out                   = mdata_reg;
  assign move_write_out                  = mwr_reg;
  assign mac_busy_out                    = (mac_st_reg == DMSAU_RUN);
  assign ptr_access_addr_out             = paddr_reg;
  assign pointer_select_out              = sel_reg;
  assign mmr_rdata_out                   = mmr_rd_reg ? ptr_rd : WORD_RESET;
endmodule
`default_nettype wire

//--- tb/dmsau_core_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module dmsau_core_assertions
  import dmsau_pkg::*;
(
  input wire logic                    clk_sys_in,
  input wire logic                    reset_n_in,
  input wire logic                    signed_multiply_op_in,
  input wire logic                    unsigned_multiply_op_in,
  input wire logic [WORD_W-1:0]       mult_data_in,
  input wire logic [WORD_W-1:0]       multiplier_operand_register_out,
  input wire logic [WIDE_W-1:0]       product_register_out,
  input wire logic [WIDE_W-1:0]       product_shifted_out,
  input wire logic [1:0]              product_shift_field_in,
  input wire logic                    bit_logic_unit_en_in,
  input wire dmsau_pkg::dmsau_bitop_e bit_op_in,
  input wire logic                    bit_write_out,
  input wire logic [WIDE_W-1:0]       main_sum_register_out,
  input wire logic                    mac_start_in,
  input wire logic                    repeat_clear_op_in,
  input wire logic [7:0]              repeat_count_in,
  input wire logic [WORD_W-1:0]       coef_start_in,
  input wire logic [WORD_W-1:0]       coef_addr_out,
  input wire logic                    mac_busy_out,
  input wire logic                    mmr_rd_in,
  input wire logic [WORD_W-1:0]       mmr_addr_in,
  input wire logic [WORD_W-1:0]       mmr_rdata_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);
  logic idle;
  assign idle = !mac_busy_out && !mac_start_in;
  function automatic logic [31:0] ps_shift(input logic [31:0] p, input logic [1:0] m);
    case (m)
      2'h0: return p;
      2'h1: return p << 1;
      2'h2: return p << PS_LEFT4_AMT;
      default: return $signed(p) >>> PS_RIGHT_AMT;
    endcase
  endfunction
  property p_smul;
    signed_multiply_op_in && !unsigned_multiply_op_in && idle |=> $signed(product_register_out) ==
      $signed($past(multiplier_operand_register_out)) * $signed($past(mult_data_in));
  endproperty
  a_smul: assert property (p_smul) else $error("signed product wrong");
  property p_umul;
    unsigned_multiply_op_in && !signed_multiply_op_in && idle |=>
      product_register_out == $past(multiplier_operand_register_out) * $past(mult_data_in);
  endproperty
  a_umul: assert property (p_umul) else $error("unsigned product wrong");
  property p_ps;
    $stable(product_shift_field_in) |-> product_shifted_out == ps_shift(product_register_out, product_shift_field_in);
  endproperty
  a_ps: assert property (p_ps) else $error("product shift wrong");
  property p_bitw;
    bit_logic_unit_en_in |=> bit_write_out == ($past(bit_op_in) != DMSAU_BIT_TEST);
  endproperty
  a_bitw: assert property (p_bitw) else $error("bit write strobe wrong");
  property p_bitsum;
    bit_logic_unit_en_in && idle |=> $stable(main_sum_register_out);
  endproperty
  a_bitsum: assert property (p_bitsum) else $error("bit op moved sum");
  property p_repeat_clear_op;
    mac_start_in && repeat_clear_op_in && !mac_busy_out |=> main_sum_register_out == 32'h0 && product_register_out == 32'h0;
  endproperty
  a_repeat_clear_op: assert property (p_repeat_clear_op) else $error("clear start left values");
  property p_busy1;
    mac_start_in && !mac_busy_out && repeat_count_in == 8'h00 |=> mac_busy_out ##1 !mac_busy_out;
  endproperty
  a_busy1: assert property (p_busy1) else $error("single run length wrong");
  property p_coef;
    mac_start_in && !mac_busy_out |=> mac_busy_out && coef_addr_out == $past(coef_start_in);
  endproperty
  a_coef: assert property (p_coef) else $error("coefficient start wrong");
  property p_coefinc;
    mac_busy_out && $past(mac_busy_out) |-> coef_addr_out == $past(coef_addr_out) + 16'h0001;
  endproperty
  a_coefinc: assert property (p_coefinc) else $error("coefficient step wrong");
  property p_mmr0;
    mmr_rd_in && (mmr_addr_in < PTR_MMR_BASE || mmr_addr_in > PTR_MMR_BASE + 16'h0007) |=> mmr_rdata_out == 16'h0000;
  endproperty
  a_mmr0: assert property (p_mmr0) else $error("unmapped read not zero");
  c_repeat_clear_op: cover property (mac_start_in && repeat_clear_op_in && !mac_busy_out);
  c_umul: cover property (unsigned_multiply_op_in && idle);
  c_run: cover property (mac_busy_out ##1 mac_busy_out ##1 mac_busy_out);
endmodule
bind dmsau_core dmsau_core_assertions u_chk (.*);
`default_nettype wire

//--- tb/dmsau_mem_model.sv
`timescale 1ns/10ps
`default_nettype none
module dmsau_mem_model
  import dmsau_pkg::*;
(
  input  wire logic              clk_sys_in,
  input  wire logic              busy_in,
  input  wire logic [WORD_W-1:0] coef_addr_in,
  input  wire logic [WORD_W-1:0] data_addr_in,
  input  wire logic [WORD_W-1:0] move_addr_in,
  input  wire logic [WORD_W-1:0] move_data_in,
  input  wire logic              move_write_in,
  output logic      [WORD_W-1:0] prog_data_out,
  output logic      [WORD_W-1:0] data_bus_out
);
  logic [WORD_W-1:0] mem [64];
  logic [WORD_W-1:0] coef_word;
  logic [WORD_W-1:0] data_word;
  initial begin
    for (int i = 0; i < 64; i++) begin
      mem[i] = 16'(i + 2);
    end
  end
  assign coef_word = {8'h00, coef_addr_in[7:0]} + 16'h0001;
  assign data_word = mem[data_addr_in[5:0]];
  // Idle buses are not held, so show the inverse
  assign prog_data_out = busy_in ? coef_word : ~coef_word;
  assign data_bus_out = busy_in ? data_word : ~data_word;
  always @(posedge clk_sys_in) begin
    if (move_write_in) begin
      mem[move_addr_in[5:0]] <= move_data_in;
    end
  end
endmodule
`default_nettype wire

//--- tb/dmsau_core_tb.sv
`timescale 1ns/10ps
`default_nettype none
module dmsau_core_tb;
  import dmsau_pkg::*;
  logic clk_sys_in = 1'b0, reset_n_in = 1'b0, scale_use_count_in = 1'b0, sign_extend_mode_in = 1'b0;
  logic bit_logic_unit_en_in = 1'b0, operand_load_op_in = 1'b0, signed_multiply_op_in = 1'b0;
  logic unsigned_multiply_op_in = 1'b0, mac_start_in = 1'b0, repeat_clear_op_in = 1'b0, mac_move_in = 1'b0;
  logic ptr_load_in = 1'b0, pointer_select_load_in = 1'b0, ptr_access_in = 1'b0, mmr_rd_in = 1'b0, mmr_wr_in = 1'b0;
  logic [4:0] scale_imm_in = 5'h00;
  logic [3:0] shift_count_register_in = 4'h0;
  logic [1:0] product_shift_field_in = 2'h0;
  logic [7:0] repeat_count_in = 8'h00;
  logic [2:0] ptr_load_idx_in = 3'h0, pointer_select_in = 3'h0, pointer_select_out;
  logic [15:0] scale_data_in = 16'h0000, bit_mem_in = 16'h0000, bit_mask_in = 16'h0000, operand_data_in = 16'h0000;
  logic [15:0] mult_data_in = 16'h0000, coef_start_in = 16'h0000, ptr_mem_in = 16'h0000, ptr_imm_in = 16'h0000;
  logic [15:0] index_step_register_in = 16'h0000, mmr_addr_in = 16'h0000, mmr_wdata_in = 16'h0000;
  dmsau_bitop_e bit_op_in = DMSAU_BIT_SET;
  dmsau_step_e mac_step_in = DMSAU_STEP_NONE, ptr_step_in = DMSAU_STEP_NONE;
  dmsau_lsrc_e ptr_src_in = DMSAU_LSRC_MEM;
  logic [15:0] prog_data_in, data_bus_in, multiplier_operand_register_out, bit_result_out, coef_addr_out;
  logic [15:0] data_addr_out, move_addr_out, move_data_out, ptr_access_addr_out, mmr_rdata_out;
  logic [31:0] scale_result_out, product_register_out, product_shifted_out, main_sum_register_out, sum_exp;
  logic bit_write_out, bit_test_out, move_write_out, mac_busy_out;
  int n_fail = 0;
  int checks_done = 0;
  dmsau_core u_dut (.*);
  dmsau_mem_model u_mem (.clk_sys_in, .busy_in(mac_busy_out), .coef_addr_in(coef_addr_out),
    .data_addr_in(data_addr_out), .move_addr_in(move_addr_out), .move_data_in(move_data_out),
    .move_write_in(move_write_out), .prog_data_out(prog_data_in), .data_bus_out(data_bus_in));
  always #(CLK_PERIOD_NS / 2) clk_sys_in = ~clk_sys_in;
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  function automatic logic [31:0] ps_exp(input logic [31:0] p, input logic [1:0] m);
    case (m)
      2'h0: return p;
      2'h1: return p << 1;
      2'h2: return p << PS_LEFT4_AMT;
      default: return $signed(p) >>> PS_RIGHT_AMT;
    endcase
  endfunction
  task automatic scale(input logic [4:0] sh, input logic cnt, input logic sx);
    logic [31:0] ext;
    @(posedge clk_sys_in);
    scale_data_in <= sh[1] ? 16'h8001 : 16'h7FF3;
    scale_imm_in <= cnt ? ~sh : sh;
    shift_count_register_in <= cnt ? sh[3:0] : ~sh[3:0];
    scale_use_count_in <= cnt;
    sign_extend_mode_in <= sx;
    @(posedge clk_sys_in);
    #1;
    ext = sx ? {{16{scale_data_in[15]}}, scale_data_in} : {16'h0000, scale_data_in};
    check("scaler", scale_result_out, ext << sh);
  endtask
  task automatic bit_op(input dmsau_bitop_e op, input logic [15:0] mask);
    logic [15:0] exp;
    @(posedge clk_sys_in);
    bit_logic_unit_en_in <= 1'b1;
    bit_op_in <= op;
    bit_mem_in <= 16'hA5F0;
    bit_mask_in <= mask;
    @(posedge clk_sys_in);
    bit_logic_unit_en_in <= 1'b0;
    #1;
    exp = (op == DMSAU_BIT_SET) ? 16'hA5F0 | mask : (op == DMSAU_BIT_CLEAR) ? 16'hA5F0 & ~mask : 16'hA5F0 ^ mask;
    if (op == DMSAU_BIT_TEST) begin
      check("bit test", {31'h0, bit_test_out}, {31'h0, |(16'hA5F0 & mask)});
    end else begin
      check("bit result", {16'h0000, bit_result_out}, {16'h0000, exp});
    end
    check("bit write", {31'h0, bit_write_out}, {31'h0, op != DMSAU_BIT_TEST});
    check("sum kept", main_sum_register_out, sum_exp);
  endtask
  task automatic ptr_load(input dmsau_lsrc_e s, input logic [2:0] i, input logic [15:0] v);
    @(posedge clk_sys_in);
    ptr_load_in <= 1'b1;
    ptr_src_in <= s;
    ptr_load_idx_in <= i;
    ptr_mem_in <= (s == DMSAU_LSRC_IMM) ? ~v : v;
    ptr_imm_in <= (s == DMSAU_LSRC_IMM) ? v : ~v;
    @(posedge clk_sys_in);
    ptr_load_in <= 1'b0;
  endtask
  task automatic mmr_read(input logic [15:0] a, input logic [15:0] exp);
    @(posedge clk_sys_in);
    mmr_rd_in <= 1'b1;
    mmr_addr_in <= a;
    @(posedge clk_sys_in);
    mmr_rd_in <= 1'b0;
    #1 check("mapped read", {16'h0000, mmr_rdata_out}, {16'h0000, exp});
  endtask
  task automatic access(input dmsau_step_e s, input logic [15:0] exp);
    @(posedge clk_sys_in);
    ptr_access_in <= 1'b1;
    ptr_step_in <= s;
    @(posedge clk_sys_in);
    ptr_access_in <= 1'b0;
    #1 check("access address", {16'h0000, ptr_access_addr_out}, {16'h0000, exp});
  endtask
  task automatic mac_run(input logic clr, input logic [7:0] n);
    int i;
    @(posedge clk_sys_in);
    mac_start_in <= 1'b1;
    repeat_clear_op_in <= clr;
    mac_move_in <= 1'b1;
    repeat_count_in <= n;
    coef_start_in <= 16'h0020;
    mac_step_in <= DMSAU_STEP_DEC;
    @(posedge clk_sys_in);
    mac_start_in <= 1'b0;
    #1;
    for (i = 0; i < 300 && mac_busy_out !== 1'b0; i++) begin
      @(posedge clk_sys_in);
      #1;
    end
    check("run cycles", 32'(i), 32'(n) + 32'h1);
  endtask
  initial begin
    logic [31:0] up;
    logic signed [31:0] sp;
    repeat (20) @(posedge clk_sys_in);
    reset_n_in <= 1'b1;
    for (int i = 0; i <= SHIFT_MAX; i++) scale(5'(i), 1'b0, i[0]);
    for (int i = 0; i < 16; i += 5) scale(5'(i), 1'b1, 1'b1);
    // Operand load and multiply on adjacent edges
    @(posedge clk_sys_in);
    operand_load_op_in <= 1'b1;
    operand_data_in <= 16'h8123;
    @(posedge clk_sys_in);
    operand_load_op_in <= 1'b0;
    signed_multiply_op_in <= 1'b1;
    mult_data_in <= 16'h7001;
    @(posedge clk_sys_in);
    signed_multiply_op_in <= 1'b0;
    unsigned_multiply_op_in <= 1'b1;
    mult_data_in <= 16'hFFFF;
    #1;
    sp = $signed(operand_data_in) * $signed(16'h7001);
    check("signed product", product_register_out, sp);
    check("operand", {16'h0000, multiplier_operand_register_out}, 32'h00008123);
    @(posedge clk_sys_in);
    unsigned_multiply_op_in <= 1'b0;
    #1;
    up = operand_data_in * mult_data_in;
    check("unsigned product", product_register_out, up);
    for (int m = 0; m < 4; m++) begin
      @(posedge clk_sys_in);
      product_shift_field_in <= 2'(m);
      @(posedge clk_sys_in);
      #1 check("product shift", product_shifted_out, ps_exp(up, 2'(m)));
    end
    @(posedge clk_sys_in);
    product_shift_field_in <= 2'h0;
    ptr_load(DMSAU_LSRC_IMM, 3'h0, 16'h000C);
    mac_run(1'b0, 8'h00);
    ptr_load(DMSAU_LSRC_IMM, 3'h0, 16'h000C);
    mac_run(1'b1, 8'h03);
    sum_exp = 32'h0000052C;
    check("sum", main_sum_register_out, sum_exp);
    check("last product", product_register_out, 32'h0000018C);
    mmr_read(PTR_MMR_BASE, 16'h0008);
    check("moved top", {16'h0000, u_mem.mem[13]}, 32'h0000000E);
    check("moved low", {16'h0000, u_mem.mem[10]}, 32'h0000000B);
    ptr_load(DMSAU_LSRC_SUM, 3'h1, 16'h0000);
    ptr_load(DMSAU_LSRC_PROD, 3'h2, 16'h0000);
    ptr_load(DMSAU_LSRC_MEM, 3'h3, 16'h0100);
    mmr_read(16'h0011, 16'h052C);
    mmr_read(16'h0012, 16'h018C);
    mmr_read(16'h0013, 16'h0100);
    for (int i = 0; i < 4; i++) bit_op(dmsau_bitop_e'(i), 16'h0FF0);
    bit_op(DMSAU_BIT_TEST, 16'h000F);
    for (int s = 7; s >= 3; s -= 4) begin
      @(posedge clk_sys_in);
      pointer_select_load_in <= 1'b1;
      pointer_select_in <= 3'(s);
      index_step_register_in <= 16'h0005;
      @(posedge clk_sys_in);
      pointer_select_load_in <= 1'b0;
      #1 check("select", {29'h0, pointer_select_out}, 32'(s));
    end
    access(DMSAU_STEP_INC, 16'h0100);
    access(DMSAU_STEP_DEC, 16'h0101);
    access(DMSAU_STEP_INDEX, 16'h0100);
    access(DMSAU_STEP_NONE, 16'h0105);
    access(DMSAU_STEP_NONE, 16'h0105);
    @(posedge clk_sys_in);
    mmr_wr_in <= 1'b1;
    mmr_addr_in <= 16'h0017;
    mmr_wdata_in <= 16'hBEEF;
    @(posedge clk_sys_in);
    mmr_wr_in <= 1'b0;
    mmr_read(16'h0017, 16'hBEEF);
    mmr_read(16'h0018, 16'h0000);
    mmr_read(16'h000F, 16'h0000);
    end_sim();
  end
  initial begin
    repeat (3000) @(posedge clk_sys_in);
    n_fail++;
    end_sim();
  end
endmodule
`default_nettype wire
